// [dv/sgcsp_checker.sv]
// concurrent checks on the ports of the storm/priority register bank
`timescale 1ns/1ps
module sgcsp_checker #(
  parameter int NUM_PORTS = 3
) (
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic [7:0]            mgmt_addr,
  input wire logic                  mgmt_wr,
  input wire logic                  mgmt_rd,
  input wire logic [7:0]            mgmt_wdata,
  input wire logic [7:0]            mgmt_rdata,
  input wire logic                  mgmt_rvalid,
  input wire logic [NUM_PORTS-1:0]  port_speed_10,
  input wire logic [NUM_PORTS-1:0]  bcast_block_valid,
  input wire logic [NUM_PORTS-1:0]  bcast_drop,
  input wire logic [10:0]           storm_threshold,
  input wire logic [1:0]            hif_clk_sel,
  input wire logic                  hif_clk_en,
  input wire logic                  rx_tag_valid,
  input wire logic [2:0]            rx_tag_pcp,
  input wire logic                  rx_prio_valid,
  input wire logic [1:0]            rx_prio,
  input wire logic                  rx_prio_mapped
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ****
  // register bank
  // ****
  sequence slow_en_s;
    (hif_clk_sel == 2'h0)[*5] ##0 hif_clk_en && !mgmt_wr;
  endsequence
  sequence no_wr_s;
    (!mgmt_wr)[*3];
  endsequence

  chk_rd_latency: assert property (mgmt_rvalid == $past(mgmt_rd))
    else $error("read answer not one cycle after the strobe");
  chk_ft_fixed: assert property (mgmt_rd && mgmt_addr inside {8'h08, 8'h09, 8'h0a} |=>
    mgmt_rdata == ($past(mgmt_addr) == 8'h08 ? 8'h00 : $past(mgmt_addr) == 8'h09 ? 8'h24 : 8'h35))
    else $error("factory test register value wrong");
  chk_thr_lo_wr: assert property (mgmt_wr && mgmt_addr == 8'h07 |=>
    storm_threshold[7:0] == $past(mgmt_wdata))
    else $error("threshold low byte not written");
  chk_thr_hi_wr: assert property (mgmt_wr && mgmt_addr == 8'h06 |=>
    {5'h00, storm_threshold[10:8]} == ($past(mgmt_wdata) & 8'h07))
    else $error("threshold high bits not written");
  chk_reset_vals: assert property ($fell(rst) |-> storm_threshold == 11'h063 && hif_clk_sel == 2'h2)
    else $error("threshold or clock select reset value wrong");
  chk_sel_wr: assert property (mgmt_wr && mgmt_addr == 8'h0b |=>
    {6'h00, hif_clk_sel} == ($past(mgmt_wdata) >> 6))
    else $error("clock select not written");
  chk_slow_rate: assert property (slow_en_s ##1 no_wr_s |=> hif_clk_en)
    else $error("slow interface clock enable not every fourth cycle");
  chk_prio_map: assert property (rx_tag_valid |=>
    rx_prio_valid && rx_prio_mapped == ($past(rx_tag_pcp) < 3'h4))
    else $error("priority lookup answer wrong");
  chk_drop_cause: assert property (bcast_drop[0] |-> $past(bcast_block_valid[0]))
    else $error("drop without a block");
  chk_zero_thr: assert property (storm_threshold == 11'h000 && bcast_block_valid[0] |=> bcast_drop[0])
    else $error("block passed with zero threshold");
endmodule // sgcsp_checker

bind sgcsp_top sgcsp_checker #(.NUM_PORTS(NUM_PORTS)) u_sgcsp_checker (
  .clock(clock), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
  .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
  .port_speed_10(port_speed_10), .bcast_block_valid(bcast_block_valid), .bcast_drop(bcast_drop),
  .storm_threshold(storm_threshold), .hif_clk_sel(hif_clk_sel), .hif_clk_en(hif_clk_en),
  .rx_tag_valid(rx_tag_valid), .rx_tag_pcp(rx_tag_pcp), .rx_prio_valid(rx_prio_valid),
  .rx_prio(rx_prio), .rx_prio_mapped(rx_prio_mapped)
);

// [dv/sgcsp_host_model.sv]
// host processor model driving the management register port
`timescale 1ns/1ps
module sgcsp_host_model (
  input  wire logic       clock,
  output logic [7:0]      mgmt_addr,
  output logic            mgmt_wr,
  output logic            mgmt_rd,
  output logic [7:0]      mgmt_wdata,
  input  wire logic [7:0] mgmt_rdata,
  input  wire logic       mgmt_rvalid
);
  initial
  begin
    mgmt_addr = 8'h00;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_wdata = 8'h00;
  end

  // released lines show the inverse so stale values never pass
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    @(negedge clock);
    mgmt_wr = 1'b0;
    mgmt_addr = ~a;
    mgmt_wdata = ~d;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge clock);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(negedge clock);
      mgmt_rd = 1'b0;
      mgmt_addr = ~a;
      if (mgmt_rvalid === 1'b1)
      begin
        ok = 1'b1;
        d = mgmt_rdata;
      end
    end
  endtask

  // lowest interface clock when fast serial access is idle
  task automatic idle_slow();
    write(8'h0b, 8'h00);
  endtask
endmodule // sgcsp_host_model

// [dv/tb_switch_global_ctrl_storm_prio.sv]
// self-checking bench for the storm/priority register bank
`timescale 1ns/1ps
module tb_switch_global_ctrl_storm_prio;
  localparam int unsigned PER100 = 20;
  localparam int unsigned PER10  = 50;
  logic       clock, rst, mgmt_wr, mgmt_rd, mgmt_rvalid, hif_clk_en;
  logic       rx_tag_valid, rx_prio_valid, rx_prio_mapped;
  logic [7:0] mgmt_addr, mgmt_wdata, mgmt_rdata;
  logic [2:0] port_speed_10, bcast_block_valid, bcast_drop, rx_tag_pcp;
  logic [10:0] storm_threshold;
  logic [1:0] hif_clk_sel, rx_prio;
  int         n_errors = 0;
  int         n_compared = 0;
  logic [7:0] ra [8] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h30};
  logic [7:0] re [8] = '{8'h00, 8'h63, 8'h00, 8'h24, 8'h35, 8'h88, 8'h50, 8'h00};
  int         gap [3] = '{default: 0};
  int         last [3] = '{default: 0};
  logic       prev [3] = '{default: 1'b0};

  sgcsp_top #(.NUM_PORTS(3), .PERIOD_100_CYC(PER100), .PERIOD_10_CYC(PER10)) u_sgcsp_top (
    .clock(clock), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .port_speed_10(port_speed_10), .bcast_block_valid(bcast_block_valid), .bcast_drop(bcast_drop),
    .storm_threshold(storm_threshold), .hif_clk_sel(hif_clk_sel), .hif_clk_en(hif_clk_en),
    .rx_tag_valid(rx_tag_valid), .rx_tag_pcp(rx_tag_pcp), .rx_prio_valid(rx_prio_valid),
    .rx_prio(rx_prio), .rx_prio_mapped(rx_prio_mapped));
  sgcsp_host_model u_host (.clock(clock), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

  task automatic stop_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_host.read(a, d, ok);
    if (!ok)
    begin
      n_errors++;
      stop_test();
    end
    else
      check({8'h00, d}, {8'h00, exp});
  endtask

  // gap between the second and third enable pulse
  task automatic en_gap(input int exp);
    int last;
    int np;
    last = 0;
    np = 0;
    for (int c = 0; c < 24 && np < 3; c++)
    begin
      @(negedge clock);
      if (hif_clk_en === 1'b1)
      begin
        np++;
        if (np == 3)
          check(16'(c - last), 16'(exp));
        last = c;
      end
    end
    if (np < 3)
    begin
      check(16'(np), 16'h0003);
      stop_test();
    end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial
  begin
    rst = 1'b1;
    port_speed_10 = 3'h2;
    bcast_block_valid = 3'h0;
    rx_tag_valid = 1'b0;
    rx_tag_pcp = 3'h0;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    check({5'h00, storm_threshold}, 16'h0063);
    for (int i = 0; i < 8; i++)
      rd_chk(ra[i], re[i]);
    for (int i = 2; i < 5; i++)
    begin
      // the host never writes the factory registers; unmapped traffic must leave them alone
      u_host.write(ra[7], 8'hff);
      rd_chk(ra[i], re[i]);
    end
    u_host.write(8'h06, 8'hff);
    rd_chk(8'h06, 8'h07);
    u_host.write(8'h07, 8'h5a);
    check({5'h00, storm_threshold}, 16'h075a);
    for (int s = 0; s < 3; s++)
    begin
      u_host.write(8'h0b, {2'(s), 6'h3f});
      rd_chk(8'h0b, {2'(s), 6'h08});
      check({14'h0000, hif_clk_sel}, 16'(s));
      en_gap(s == 0 ? 4 : s == 1 ? 2 : 1);
    end
    u_host.idle_slow();
    u_host.write(8'h0c, 8'h1b);
    for (int t = 0; t < 8; t++)
    begin
      @(negedge clock);
      rx_tag_valid = 1'b1;
      rx_tag_pcp = 3'(t);
      @(negedge clock);
      rx_tag_valid = 1'b0;
      check({12'h000, rx_prio_mapped, rx_prio_valid, rx_prio},
            {12'h000, t < 4, 1'b1, t < 4 ? 2'(3 - t) : 2'h0});
    end
    u_host.write(8'h06, 8'h00);
    u_host.write(8'h07, 8'h00);
    bcast_block_valid = 3'h1;
    @(negedge clock);
    bcast_block_valid = 3'h0;
    check({13'h0000, bcast_drop}, 16'h0001);
    u_host.write(8'h07, 8'h02);
    bcast_block_valid = 3'h7;
    for (int c = 0; c < 200; c++)
    begin
      @(negedge clock);
      for (int p = 0; p < 3; p++)
      begin
        if (prev[p] && !bcast_drop[p])
        begin
          gap[p] = c - last[p];
          last[p] = c;
        end
        prev[p] = bcast_drop[p];
      end
    end
    bcast_block_valid = 3'h0;
    check(16'(gap[0]), 16'(PER100));
    check(16'(gap[1]), 16'(PER10));
    check(16'(gap[2]), 16'(PER100));
    stop_test();
  end
endmodule // tb_switch_global_ctrl_storm_prio

// [hdl/sgcsp_period_timer.sv]
// speed dependent storm measurement period for one port
`timescale 1ns/1ps
module sgcsp_period_timer #(
  parameter int unsigned PERIOD_100_CYC = sgcsp_pkg::PERIOD_100_CYC,
  parameter int unsigned PERIOD_10_CYC  = sgcsp_pkg::PERIOD_10_CYC
) (
  input  wire logic     clock,
  input  wire logic     rst,
  sgcsp_storm_if.timer  tmr
);

  sgcsp_pkg::sgcsp_timer_t      s_q;
  sgcsp_pkg::sgcsp_timer_t      s_d;
  sgcsp_pkg::sgcsp_period_cnt_t lim_m1;

  always_comb
  begin
    s_d      = s_q;
    lim_m1   = tmr.speed_10 ? sgcsp_pkg::sgcsp_period_cnt_t'(PERIOD_10_CYC - 1)
                            : sgcsp_pkg::sgcsp_period_cnt_t'(PERIOD_100_CYC - 1); // see RULE_02
    s_d.tick = 1'b0;
    // >= also ends a long period at once when the port drops to the short one
    if (s_q.cnt >= lim_m1)
    begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tmr.period_tick = s_q.tick;

endmodule // sgcsp_period_timer

// [hdl/sgcsp_pkg.sv]
// constants, field layouts and state types of the storm/priority register bank
package sgcsp_pkg;

  // ****************************************************************
  // register offsets on the management port
  // ****************************************************************
  localparam logic [7:0] ADDR_THR_HI   = 8'h06;
  localparam logic [7:0] ADDR_THR_LO   = 8'h07;
  localparam logic [7:0] ADDR_FT_A     = 8'h08;
  localparam logic [7:0] ADDR_FT_B     = 8'h09;
  localparam logic [7:0] ADDR_FT_C     = 8'h0a;
  localparam logic [7:0] ADDR_HIF_CLK  = 8'h0b;
  localparam logic [7:0] ADDR_PRIO_LO  = 8'h0c;
  localparam logic [7:0] RDATA_UNMAP   = 8'h00;

  // ****************************************************************
  // field layouts and reset values
  // ****************************************************************
  localparam int          NUM_PORTS    = 3;
  localparam int          THR_W        = 11;
  localparam int          THR_HI_W     = 3;
  localparam int          THR_LO_W     = 8;
  localparam logic [2:0]  THR_HI_RST   = 3'h0;
  localparam logic [7:0]  THR_LO_RST   = 8'h63;
  localparam logic [7:0]  FT_A_VAL     = 8'h00;
  localparam logic [7:0]  FT_B_VAL     = 8'h24;
  localparam logic [7:0]  FT_C_VAL     = 8'h35;
  localparam int          HIF_SEL_LSB  = 6;
  localparam int          HIF_SEL_W    = 2;
  localparam logic [5:0]  HIF_RO_BITS  = 6'h08;
  localparam logic [1:0]  HIF_SEL_31M  = 2'h0;
  localparam logic [1:0]  HIF_SEL_62M  = 2'h1;
  localparam logic [1:0]  HIF_SEL_125M = 2'h2;
  localparam logic [1:0]  HIF_SEL_RST  = HIF_SEL_125M;
  localparam int          PRIO_W       = 2;
  localparam int          PRIO_TAGS    = 4;
  localparam int          PCP_W        = 3;
  localparam logic [7:0]  PRIO_RST     = 8'h50;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          CLK_KHZ        = 125000;
  localparam int          HIF_KHZ_31M    = 31250;
  localparam int          HIF_KHZ_62M    = 62500;
  localparam int          HIF_KHZ_125M   = 125000;
  localparam int          HIF_DIV_31M    = CLK_KHZ / HIF_KHZ_31M;
  localparam int          HIF_DIV_62M    = CLK_KHZ / HIF_KHZ_62M;
  localparam int          HIF_DIV_125M   = CLK_KHZ / HIF_KHZ_125M;
  localparam int          HIF_CNT_W      = 2;
  localparam int unsigned PERIOD_100_MS  = 67;
  localparam int unsigned PERIOD_10_MS   = 500;
  localparam int unsigned PERIOD_100_CYC = PERIOD_100_MS * CLK_KHZ;
  localparam int unsigned PERIOD_10_CYC  = PERIOD_10_MS * CLK_KHZ;
  localparam int          PERIOD_CNT_W   = 26;

  typedef logic [PERIOD_CNT_W-1:0] sgcsp_period_cnt_t;
  typedef logic [HIF_CNT_W-1:0]    sgcsp_hif_cnt_t;

  // ****************************************************************
  // module state
  // ****************************************************************
  typedef struct packed {
    logic [THR_HI_W-1:0]  thr_hi;
    logic [THR_LO_W-1:0]  thr_lo;
    logic [HIF_SEL_W-1:0] hif_sel;
    logic [7:0]           prio_map;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic [HIF_CNT_W-1:0] hif_cnt;
    logic                 hif_en;
    logic                 prio_valid;
    logic [PRIO_W-1:0]    prio;
    logic                 prio_mapped;
  } sgcsp_regs_t;

  localparam sgcsp_regs_t REGS_RST = '{
    thr_hi: THR_HI_RST, thr_lo: THR_LO_RST, hif_sel: HIF_SEL_RST, prio_map: PRIO_RST,
    rdata: 8'h00, rvalid: 1'b0, hif_cnt: 2'h0, hif_en: 1'b0, prio_valid: 1'b0,
    prio: 2'h0, prio_mapped: 1'b0};

  typedef struct packed {
    logic [PERIOD_CNT_W-1:0] cnt;
    logic                    tick;
  } sgcsp_timer_t;

  typedef struct packed {
    logic [THR_W-1:0] cnt;
    logic             drop;
  } sgcsp_blk_t;

endpackage

// [hdl/sgcsp_storm_if.sv]
// per-port bundle between the register bank and the storm timer and counter
`timescale 1ns/1ps
interface sgcsp_storm_if #(
  parameter int THR_W = 11
);
  logic [THR_W-1:0] threshold;
  logic             speed_10;
  logic             period_tick;
  logic             block_valid;
  logic             drop;

  modport timer   (input speed_10, output period_tick);
  modport counter (input threshold, input period_tick, input block_valid, output drop);
  modport ctrl    (output threshold, output speed_10, output block_valid, input period_tick, input drop);
endinterface

// [hdl/sgcsp_storm_port.sv]
// broadcast block counter and discard decision for one input port
`timescale 1ns/1ps
module sgcsp_storm_port (
  input  wire logic      clock,
  input  wire logic      rst,
  sgcsp_storm_if.counter cnt_if
);

  sgcsp_pkg::sgcsp_blk_t         s_q;
  sgcsp_pkg::sgcsp_blk_t         s_d;
  logic [sgcsp_pkg::THR_W-1:0]   base;
  logic                          full;

  always_comb
  begin
    s_d   = s_q;
    // a block arriving with the tick counts in the new period
    base  = cnt_if.period_tick ? '0 : s_q.cnt;          // see RULE_04
    full  = (base >= cnt_if.threshold);                  // see RULE_01
    s_d.drop = cnt_if.block_valid & full;                // see RULE_04
    s_d.cnt  = base;
    if (cnt_if.block_valid && !full)
      s_d.cnt = base + 1'b1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign cnt_if.drop = s_q.drop;

endmodule // sgcsp_storm_port

// [hdl/sgcsp_top.sv]
// storm threshold, host interface clock select and priority map register bank
//
// Overview of operation
// RULE_01 - threshold is eleven bits: high register bits 2-0 over the low byte.
// RULE_02 - storm period is 67 ms at 100 Mbps and 500 ms at 10 Mbps.
// RULE_03 - threshold resets to 0x63: high bits zero, low byte 0x63.
// RULE_04 - per-port block count clears each period; blocks beyond threshold are dropped.
// RULE_05 - three factory test registers are read only, returning 0x00, 0x24, 0x35.
// RULE_06 - clock select bits 7-6 pick 31.25, 62.5 or 125 MHz interface clock.
// RULE_07 - clock select resets to code 10, the 125 MHz interface clock.
// RULE_08 - host should choose 31.25 MHz when fast serial access is not needed.
// RULE_09 - priority map fields give queue priority for tags 3, 2 and 1.
// RULE_10 - priority map resets tags 3 and 2 to 01, tag 1 to 00.
// RULE_11 - bits 1-0 give priority for tag 0, reset 00.
`timescale 1ns/1ps
module sgcsp_top #(
  parameter int          NUM_PORTS      = sgcsp_pkg::NUM_PORTS,
  parameter int unsigned PERIOD_100_CYC = sgcsp_pkg::PERIOD_100_CYC,
  parameter int unsigned PERIOD_10_CYC  = sgcsp_pkg::PERIOD_10_CYC
) (
  input  wire logic                           clock,
  input  wire logic                           rst,
  input  wire logic [7:0]                     mgmt_addr,
  input  wire logic                           mgmt_wr,
  input  wire logic                           mgmt_rd,
  input  wire logic [7:0]                     mgmt_wdata,
  output wire logic [7:0]                     mgmt_rdata,
  output wire logic                           mgmt_rvalid,
  input  wire logic [NUM_PORTS-1:0]           port_speed_10,
  input  wire logic [NUM_PORTS-1:0]           bcast_block_valid,
  output wire logic [NUM_PORTS-1:0]           bcast_drop,
  output wire logic [sgcsp_pkg::THR_W-1:0]    storm_threshold,
  output wire logic [sgcsp_pkg::HIF_SEL_W-1:0] hif_clk_sel,
  output wire logic                           hif_clk_en,
  input  wire logic                           rx_tag_valid,
  input  wire logic [sgcsp_pkg::PCP_W-1:0]    rx_tag_pcp,
  output wire logic                           rx_prio_valid,
  output wire logic [sgcsp_pkg::PRIO_W-1:0]   rx_prio,
  output wire logic                           rx_prio_mapped
);

  // ****************************************************************
  // decode functions
  // ****************************************************************

  // divider end count for the host interface clock enable
  function automatic sgcsp_pkg::sgcsp_hif_cnt_t hif_div_m1(
    input logic [1:0] sel
  );
    sgcsp_pkg::sgcsp_hif_cnt_t r;
    r = sgcsp_pkg::sgcsp_hif_cnt_t'(sgcsp_pkg::HIF_DIV_125M - 1);
    unique case (sel)
      sgcsp_pkg::HIF_SEL_31M:
      begin
        r = sgcsp_pkg::sgcsp_hif_cnt_t'(sgcsp_pkg::HIF_DIV_31M - 1);
      end

      sgcsp_pkg::HIF_SEL_62M:
      begin
        r = sgcsp_pkg::sgcsp_hif_cnt_t'(sgcsp_pkg::HIF_DIV_62M - 1);
      end

      sgcsp_pkg::HIF_SEL_125M:
      begin
        r = sgcsp_pkg::sgcsp_hif_cnt_t'(sgcsp_pkg::HIF_DIV_125M - 1);
      end

      // the unused code runs like the fastest setting
      default:
      begin
        r = sgcsp_pkg::sgcsp_hif_cnt_t'(sgcsp_pkg::HIF_DIV_125M - 1);
      end
    endcase
    return r;
  endfunction

  // two-bit field of the priority map belonging to a tag
  function automatic logic [sgcsp_pkg::PRIO_W-1:0] prio_field(
    input logic [7:0] map,
    input logic [1:0] tag
  );
    logic [sgcsp_pkg::PRIO_W-1:0] f;
    f = map[tag*sgcsp_pkg::PRIO_W +: sgcsp_pkg::PRIO_W];   // see RULE_09 RULE_11
    return f;
  endfunction

  // eleven bit storm threshold from its two registers
  function automatic logic [sgcsp_pkg::THR_W-1:0] thr_of(
    input sgcsp_pkg::sgcsp_regs_t r
  );
    logic [sgcsp_pkg::THR_W-1:0] t;
    t = {r.thr_hi, r.thr_lo};   // see RULE_01
    return t;
  endfunction

  // read value of one register offset
  function automatic logic [7:0] read_mux(
    input logic [7:0]             addr,
    input sgcsp_pkg::sgcsp_regs_t r
  );
    logic [7:0] v;
    v = sgcsp_pkg::RDATA_UNMAP;
    unique case (addr)
      sgcsp_pkg::ADDR_THR_HI:
      begin
        v = {{(8 - sgcsp_pkg::THR_HI_W){1'b0}}, r.thr_hi};
      end

      sgcsp_pkg::ADDR_THR_LO:
      begin
        v = r.thr_lo;
      end

      sgcsp_pkg::ADDR_FT_A:
      begin
        v = sgcsp_pkg::FT_A_VAL;                 // see RULE_05
      end

      sgcsp_pkg::ADDR_FT_B:
      begin
        v = sgcsp_pkg::FT_B_VAL;                 // see RULE_05
      end

      sgcsp_pkg::ADDR_FT_C:
      begin
        v = sgcsp_pkg::FT_C_VAL;                 // see RULE_05
      end

      sgcsp_pkg::ADDR_HIF_CLK:
      begin
        v = {r.hif_sel, sgcsp_pkg::HIF_RO_BITS};
      end

      sgcsp_pkg::ADDR_PRIO_LO:
      begin
        v = r.prio_map;
      end

      default:
      begin
        v = sgcsp_pkg::RDATA_UNMAP;
      end
    endcase
    return v;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  sgcsp_pkg::sgcsp_regs_t s_q;
  sgcsp_pkg::sgcsp_regs_t s_d;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;

    // ****************************************************************
    // register writes; read only and unmapped offsets ignore writes
    // ****************************************************************
    if (mgmt_wr)
    begin
      unique case (mgmt_addr)
        sgcsp_pkg::ADDR_THR_HI:
        begin
          // only the three threshold bits exist; the rest read back as zero
          s_d.thr_hi = mgmt_wdata[sgcsp_pkg::THR_HI_W-1:0];                      // see RULE_01
        end

        sgcsp_pkg::ADDR_THR_LO:
        begin
          s_d.thr_lo = mgmt_wdata;                                               // see RULE_01
        end

        sgcsp_pkg::ADDR_HIF_CLK:
        begin
          s_d.hif_sel = mgmt_wdata[sgcsp_pkg::HIF_SEL_LSB +: sgcsp_pkg::HIF_SEL_W]; // see RULE_06
        end

        sgcsp_pkg::ADDR_PRIO_LO:
        begin
          s_d.prio_map = mgmt_wdata;                                             // see RULE_09
        end

        default:
        begin
          s_d.prio_map = s_q.prio_map;
        end
      endcase
    end

    // ****************************************************************
    // reads answer one cycle later with the value before any same-cycle write
    // ****************************************************************
    // the read value is latched so it holds until the next read
    if (mgmt_rd)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = read_mux(mgmt_addr, s_q);
    end

    // ****************************************************************
    // host interface clock enable at the selected rate
    // ****************************************************************
    // a select write moves the divider to its new end count at once
    if (s_q.hif_cnt >= hif_div_m1(s_q.hif_sel))                                  // see RULE_06
    begin
      s_d.hif_cnt = '0;
      s_d.hif_en  = 1'b1;
    end
    else
    begin
      s_d.hif_cnt = s_q.hif_cnt + 1'b1;
      s_d.hif_en  = 1'b0;
    end

    // ****************************************************************
    // tag to priority lookup; tags 4-7 are mapped elsewhere
    // ****************************************************************
    s_d.prio_valid = rx_tag_valid;
    if (rx_tag_valid)
    begin
      s_d.prio_mapped = (rx_tag_pcp < sgcsp_pkg::PCP_W'(sgcsp_pkg::PRIO_TAGS));
      // an unmapped tag reports priority zero
      if (s_d.prio_mapped)
      begin
        s_d.prio = prio_field(s_q.prio_map, rx_tag_pcp[1:0]);                   // see RULE_09
      end
      else
      begin
        s_d.prio = '0;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_q <= sgcsp_pkg::REGS_RST;   // see RULE_03 RULE_07 RULE_10 RULE_11
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // per-port storm protection
  // ****************************************************************
  logic [NUM_PORTS-1:0] drop_w;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++)
    begin : g_port
      sgcsp_storm_if #(.THR_W(sgcsp_pkg::THR_W)) sif ();

      // counters compare against the live threshold, so a write acts at once
      assign sif.threshold   = thr_of(s_q);   // see RULE_01
      assign sif.speed_10    = port_speed_10[gi];
      assign sif.block_valid = bcast_block_valid[gi];
      assign drop_w[gi]      = sif.drop;

      sgcsp_period_timer #(
        .PERIOD_100_CYC (PERIOD_100_CYC),
        .PERIOD_10_CYC  (PERIOD_10_CYC)
      ) u_timer (
        .clock (clock),
        .rst   (rst),
        .tmr   (sif.timer)
      );

      sgcsp_storm_port u_count (
        .clock  (clock),
        .rst    (rst),
        .cnt_if (sif.counter)
      );
    end
  endgenerate

  // ****************************************************************
  // outputs
  // ****************************************************************
  // every output is taken straight from a register
  assign mgmt_rdata      = s_q.rdata;
  assign mgmt_rvalid     = s_q.rvalid;
  assign bcast_drop      = drop_w;
  assign storm_threshold = thr_of(s_q);
  assign hif_clk_sel     = s_q.hif_sel;
  assign hif_clk_en      = s_q.hif_en;
  assign rx_prio_valid   = s_q.prio_valid;
  assign rx_prio         = s_q.prio;
  assign rx_prio_mapped  = s_q.prio_mapped;

endmodule // sgcsp_top
